/* core/wdrd_pkg.sv */
// ****************************************************************
// Watchdog runaway detector constants and types
// ****************************************************************
package wdrd_pkg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] dat;
  } wdrd_wb_req_t;

  localparam logic [ADR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CMD  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_NMI  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_STS  = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_MSK  = 8'h10;

  // ****************************************************************
  // Mode register fields and reset values
  // ****************************************************************
  localparam int unsigned EN_BIT    = 7;
  localparam int unsigned PER_MSB   = 6;
  localparam int unsigned PER_LSB   = 4;
  localparam int unsigned IDLE_BIT  = 2;
  localparam int unsigned REACT_BIT = 1;

  localparam logic       EN_RST    = 1'h1;
  localparam logic [2:0] PER_RST   = 3'h0;
  localparam logic       IDLE_RST  = 1'h0;
  localparam logic       REACT_RST = 1'h1;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_DISABLE = 8'hB1;
  localparam logic [7:0] CMD_CLEAR   = 8'h4E;

  // ****************************************************************
  // Counter and internal reset timing
  // ****************************************************************
  localparam int unsigned CNT_W        = 25;
  localparam int unsigned PER_BASE_EXP = 15;
  localparam int unsigned PER_STEP     = 2;
  localparam logic [2:0]  PER_MAX_CODE = 3'h5;
  localparam int unsigned RST_STATES   = 32;
  localparam int unsigned RST_CNT_W    = 6;

  // ****************************************************************
  // Event bits of the status, mask and source flag registers
  // ****************************************************************
  localparam int unsigned EV_W    = 2;
  localparam int unsigned EV_NMI  = 0;
  localparam int unsigned EV_RST  = 1;
  localparam int unsigned NMI_WDT = 0;

  typedef struct packed {
    logic                 ack;
    logic [DAT_W-1:0]     rdat;
    logic                 en_bit;
    logic                 active;
    logic [2:0]           period;
    logic                 idle_run;
    logic                 react;
    logic [CNT_W-1:0]     cnt;
    logic                 out_n;
    logic                 irq_pulse;
    logic                 nmi_flag;
    logic                 rst_act;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [EV_W-1:0]      sts;
    logic [EV_W-1:0]      msk;
  } wdrd_state_t;

endpackage

/* core/wdrd_top.sv */
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module wdrd_top #(
  parameter int unsigned PER_BASE_EXP = wdrd_pkg::PER_BASE_EXP
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire wdrd_pkg::wdrd_wb_req_t wb_req,
  output logic                       wb_ack,
  output logic [wdrd_pkg::DAT_W-1:0] wb_dat_o,
  input  wire logic                  dbg_halt,
  input  wire logic                  idle_mode,
  output logic                       watchdog_irq,
  output logic                       watchdog_out_n,
  output logic                       int_rst_n,
  output logic                       clk_sel_osc,
  output logic                       irq
);
  import wdrd_pkg::*;

  // ****************************************************************
  // Reset image of the state
  // ****************************************************************
  localparam wdrd_state_t ST_RST = '{
    ack:       1'h0,
    rdat:      32'h0,
    en_bit:    EN_RST,
    active:    EN_RST,
    period:    PER_RST,
    idle_run:  IDLE_RST,
    react:     REACT_RST,
    cnt:       25'h0,
    out_n:     1'h1,
    irq_pulse: 1'h0,
    nmi_flag:  1'h0,
    rst_act:   1'h0,
    rst_cnt:   6'h0,
    sts:       2'h0,
    msk:       2'h0
  };

  localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(RST_STATES - 1);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Last count before overflow; prohibited codes act as the longest period.
  function automatic logic [CNT_W-1:0] last_count(input logic [2:0] code);
    logic [2:0]     c;
    int unsigned    e;
    logic [63:0]    span;
    c = (code > PER_MAX_CODE) ? PER_MAX_CODE : code;
    e = PER_BASE_EXP + PER_STEP * int'(c);
    span = (64'h1 << e) - 64'h1;
    return span[CNT_W-1:0];
  endfunction

  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [ADR_W-1:0] ofs);
    return adr == ofs;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  wdrd_state_t st_ff;
  wdrd_state_t nxt_st;

  logic       acc;
  logic       wr;
  logic [7:0] wbyte;
  logic       cnt_run;
  logic       ovf;
  logic       ovf_nmi;
  logic       ovf_rst;

  always_comb begin
    nxt_st = st_ff;
    acc = wb_req.cyc & wb_req.stb & ~st_ff.ack;
    wr = acc & wb_req.we & wb_req.sel[0];
    wbyte = wb_req.dat[7:0];

    // Counting gates: disabled, debug halt, idle without run bit, reset hold.
    cnt_run = st_ff.active & ~dbg_halt & (~idle_mode | st_ff.idle_run)
              & ~st_ff.rst_act;
    ovf = cnt_run & (st_ff.cnt == last_count(st_ff.period));
    ovf_nmi = ovf & ~st_ff.react;
    ovf_rst = ovf & st_ff.react;

    // ****************************************************************
    // Bus handshake and read data
    // ****************************************************************
    nxt_st.ack = acc;
    nxt_st.rdat = '0;
    if (acc & ~wb_req.we) begin
      if (hit(wb_req.adr, OFS_MODE)) begin
        nxt_st.rdat[EN_BIT] = st_ff.en_bit;
        nxt_st.rdat[PER_MSB:PER_LSB] = st_ff.period;
        nxt_st.rdat[IDLE_BIT] = st_ff.idle_run;
        nxt_st.rdat[REACT_BIT] = st_ff.react;
      end else if (hit(wb_req.adr, OFS_NMI)) begin
        nxt_st.rdat[NMI_WDT] = st_ff.nmi_flag;
      end else if (hit(wb_req.adr, OFS_STS)) begin
        nxt_st.rdat[EV_W-1:0] = st_ff.sts;
      end else if (hit(wb_req.adr, OFS_MSK)) begin
        nxt_st.rdat[EV_W-1:0] = st_ff.msk;
      end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    if (cnt_run) begin
      nxt_st.cnt = ovf ? '0 : st_ff.cnt + CNT_W'(1);
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (wr & hit(wb_req.adr, OFS_MODE)) begin
      nxt_st.en_bit = wbyte[EN_BIT];
      nxt_st.period = wbyte[PER_MSB:PER_LSB];
      nxt_st.idle_run = wbyte[IDLE_BIT];
      nxt_st.react = wbyte[REACT_BIT];
      if (wbyte[EN_BIT]) begin
        nxt_st.active = 1'h1;
      end
    end

    if (wr & hit(wb_req.adr, OFS_CMD)) begin
      if (wbyte == CMD_DISABLE && !st_ff.en_bit) begin
        nxt_st.active = 1'h0;
        nxt_st.cnt = '0;
      end else if (wbyte == CMD_CLEAR) begin
        nxt_st.cnt = '0;
        nxt_st.out_n = 1'h1;
      end
    end

    if (wr & hit(wb_req.adr, OFS_NMI) & wbyte[NMI_WDT]) begin
      nxt_st.nmi_flag = 1'h0;
    end
    if (wr & hit(wb_req.adr, OFS_STS)) begin
      nxt_st.sts = st_ff.sts & ~wbyte[EV_W-1:0];
    end
    if (wr & hit(wb_req.adr, OFS_MSK)) begin
      nxt_st.msk = wbyte[EV_W-1:0];
    end

    // ****************************************************************
    // Overflow reactions
    // ****************************************************************
    // Hardware events are applied last so a set beats a same-cycle clear.
    nxt_st.irq_pulse = ovf_nmi;
    if (ovf_nmi) begin
      nxt_st.nmi_flag = 1'h1;
      nxt_st.out_n = 1'h0;
      nxt_st.sts[EV_NMI] = 1'h1;
    end

    if (ovf_rst) begin
      nxt_st.rst_act = 1'h1;
      nxt_st.rst_cnt = '0;
      nxt_st.sts[EV_RST] = 1'h1;
    end

    // ****************************************************************
    // Internal reset hold
    // ****************************************************************
    // The hold reinitialises the mode register fields and the counter as a chip reset would.
    if (st_ff.rst_act) begin
      nxt_st.rst_cnt = st_ff.rst_cnt + RST_CNT_W'(1);
      if (st_ff.rst_cnt == RST_LAST) begin
        nxt_st.rst_act = 1'h0;
      end
      nxt_st.en_bit = EN_RST;
      nxt_st.active = EN_RST;
      nxt_st.period = PER_RST;
      nxt_st.idle_run = IDLE_RST;
      nxt_st.react = REACT_RST;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_ack         = st_ff.ack;
  assign wb_dat_o       = st_ff.rdat;
  assign watchdog_irq   = st_ff.irq_pulse;
  assign watchdog_out_n = st_ff.out_n;
  assign int_rst_n      = ~st_ff.rst_act;
  assign clk_sel_osc    = st_ff.rst_act;
  assign irq            = |(st_ff.sts & st_ff.msk);

endmodule

/* verif/wdrd_monitor.sv */
`timescale 1ns/1ns
module wdrd_monitor (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire wdrd_pkg::wdrd_wb_req_t wb_req,
  input wire logic                  wb_ack,
  input wire logic [wdrd_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic                  watchdog_irq,
  input wire logic                  watchdog_out_n,
  input wire logic                  int_rst_n,
  input wire logic                  clk_sel_osc
);
  import wdrd_pkg::*;
  logic       clr_take;
  logic [5:0] low_ff;
  // Marks the edge at which a clear command is taken from the bus.
  assign clr_take = wb_req.cyc && wb_req.stb && !wb_ack && wb_req.we && wb_req.sel[0]
                    && wb_req.adr == OFS_CMD && wb_req.dat[7:0] == CMD_CLEAR;
  always_ff @(posedge clk) begin
    low_ff <= (!rst_n || int_rst_n) ? 6'h00 : low_ff + 6'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ack_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
    else $error("ack did not follow the request");
  chk_data_idle: assert property (!wb_ack |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_irq_pulse: assert property (watchdog_irq |=> !watchdog_irq)
    else $error("watchdog irq longer than one cycle");
  chk_irq_out_low: assert property (watchdog_irq |-> !watchdog_out_n)
    else $error("watchdog output not low with irq");
  chk_out_clear: assert property ($rose(watchdog_out_n) |-> $past(clr_take))
    else $error("watchdog output rose without clear");
  chk_rst_length: assert property ($rose(int_rst_n) |-> low_ff == 6'h20)
    else $error("internal reset length wrong");
  chk_osc_follow: assert property (clk_sel_osc != int_rst_n)
    else $error("oscillator select not tied to internal reset");
  chk_out_fall: assert property ($fell(watchdog_out_n) |-> watchdog_irq)
    else $error("watchdog output fell without irq");
  chk_hold_quiet: assert property (!int_rst_n |-> !watchdog_irq)
    else $error("watchdog irq during internal reset");
endmodule

/* verif/wdrd_bench.sv */
`timescale 1ns/1ns
module wdrd_bench;
  import wdrd_pkg::*;
  logic             clk = 1'h0;
  logic             rst_n = 1'h0;
  logic             dbg = 1'h0;
  logic             idle = 1'h0;
  wdrd_wb_req_t     req = '0;
  logic             ack, wirq, outn, irstn, osc, irq;
  logic [DAT_W-1:0] rdat, q;
  int               bad_count = 0;
  int               check_count = 0;
  int               n;
  wdrd_top #(.PER_BASE_EXP(3)) DUT (.clk(clk), .rst_n(rst_n), .wb_req(req), .wb_ack(ack),
    .wb_dat_o(rdat), .dbg_halt(dbg), .idle_mode(idle), .watchdog_irq(wirq),
    .watchdog_out_n(outn), .int_rst_n(irstn), .clk_sel_osc(osc), .irq(irq));
  always #50 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 50);
    q = rdat;
    req <= '0;
    if (ack !== 1'h1) begin
      bad_count++;
      give_verdict();
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    check(q, e);
  endtask
  // Counts edges until the sampled signal takes the given level, or the limit.
  task automatic wt(ref logic s, input logic v, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== v && n < lim);
  endtask
  // A wait whose event must come: running out of its limit ends the run.
  task automatic wh(ref logic s, input logic v, input int lim);
    wt(s, v, lim);
    if (s !== v) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic t_boot();
    rd(OFS_MODE, 32'h82);
    wh(irstn, 1'h0, 100);
    check(n, 32'h6);
    check(osc, 1'h1);
    wh(irstn, 1'h1, 100);
    check(n, 32'h20);
    check(osc, 1'h0);
    wb(1'h1, OFS_MODE, 32'h80);
    rd(OFS_STS, 32'h2);
    rd(OFS_CMD, 32'h0);
    rd(8'h20, 32'h0);
    $display("boot test done");
  endtask
  task automatic t_nmi();
    wh(wirq, 1'h1, 20);
    check(outn, 1'h0);
    rd(OFS_NMI, 32'h1);
    wb(1'h1, OFS_NMI, 32'h1);
    rd(OFS_NMI, 32'h0);
    wb(1'h1, OFS_MSK, 32'h1);
    check(irq, 1'h1);
    wb(1'h1, OFS_MSK, 32'h0);
    check(irq, 1'h0);
    wb(1'h1, OFS_CMD, 32'h4E);
    check(outn, 1'h1);
    wh(wirq, 1'h1, 20);
    check(n, 32'h7);
    for (int c = 0; c < 6; c++) begin
      wb(1'h1, OFS_MODE, 32'h80 | (c << 4));
      wh(wirq, 1'h1, 40000);
      wh(wirq, 1'h1, 40000);
      check(n, 1 << (3 + 2 * c));
    end
    wb(1'h1, OFS_CMD, 32'h4E);
    wb(1'h1, OFS_MODE, 32'h80);
    $display("interrupt test done");
  endtask
  task automatic t_disable();
    wh(wirq, 1'h1, 20);
    wb(1'h1, OFS_CMD, 32'h55);
    wb(1'h1, OFS_CMD, 32'hB1);
    wh(wirq, 1'h1, 20);
    check(n, 32'h2);
    wb(1'h1, OFS_MODE, 32'h0);
    wh(wirq, 1'h1, 20);
    check(n, 32'h5);
    wb(1'h1, OFS_CMD, 32'hB1);
    wt(wirq, 1'h1, 40);
    check(n, 32'h28);
    wb(1'h1, OFS_MSK, 32'h1);
    check(irq, 1'h1);
    wb(1'h1, OFS_STS, 32'h3);
    rd(OFS_STS, 32'h0);
    check(irq, 1'h0);
    wb(1'h1, OFS_MODE, 32'h80);
    wh(wirq, 1'h1, 20);
    check(n, 32'h7);
    $display("disable test done");
  endtask
  task automatic t_halt();
    dbg <= 1'h1;
    wt(wirq, 1'h1, 20);
    check(n, 32'h14);
    dbg <= 1'h0;
    wh(wirq, 1'h1, 20);
    check(n, 32'h8);
    idle <= 1'h1;
    wt(wirq, 1'h1, 20);
    check(n, 32'h14);
    idle <= 1'h0;
    wh(wirq, 1'h1, 20);
    wb(1'h1, OFS_MODE, 32'h84);
    wh(wirq, 1'h1, 20);
    idle <= 1'h1;
    wh(wirq, 1'h1, 20);
    check(n, 32'h8);
    idle <= 1'h0;
    $display("halt test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_boot();
    t_nmi();
    t_disable();
    t_halt();
    give_verdict();
  end
endmodule
bind wdrd_top wdrd_monitor u_mon (.clk, .rst_n, .wb_req, .wb_ack, .wb_dat_o, .watchdog_irq,
  .watchdog_out_n, .int_rst_n, .clk_sel_osc);
